// ==== include/charger_params.svh ====
// constants for the charger enable / pwm control block
// assumes a 125 MHz core clock and a 16-bit register port
`ifndef CHARGER_PARAMS_SVH
`define CHARGER_PARAMS_SVH

// ---------------------------------------------------------
// register map (word offsets on the plain port)
// ---------------------------------------------------------
`define ADDR_OPTION       4'h0
`define ADDR_TGT_VOLTAGE  4'h1
`define ADDR_TGT_CURRENT  4'h2
`define ADDR_IN_CURRENT   4'h3
`define ADDR_STATUS       4'h4

// ---------------------------------------------------------
// option word fields and reset values
// ---------------------------------------------------------
`define OPT_INHIBIT_BIT   0
`define OPT_INPUT_OVERCURRENT_EN_BIT   1
`define OPT_MON_SEL_BIT   5
`define OPT_WD_HI         14
`define OPT_WD_LO         13
`define OPTION_RESET      16'h6002
`define WD_OFF            2'h0
`define WD_44S            2'h1
`define WD_88S            2'h2
`define WD_175S           2'h3

// ---------------------------------------------------------
// limit ranges and soft-start current steps (mA codes)
// ---------------------------------------------------------
`define VOLT_MAX          16'h4B00
`define CURR_MAX          16'h1FC0
`define INCUR_MAX         16'h1F80
`define SS_START          16'h0080
`define SS_STEP_CCM       16'h0040
`define SS_STEP_DCM       16'h0080

// ---------------------------------------------------------
// timing
// ---------------------------------------------------------
`define CLK_NS            8
`define SS_CCM_NS         240000
`define SS_DCM_NS         480000
`define BLANK_NS          4200000
`define TICK_NS           1000000
`define SS_CCM_CYC        (`SS_CCM_NS / `CLK_NS)
`define SS_DCM_CYC        (`SS_DCM_NS / `CLK_NS)
`define BLANK_CYC         (`BLANK_NS / `CLK_NS)
`define TICK_CYC          (`TICK_NS / `CLK_NS)
`define WD_44S_MS         18'd44000
`define WD_88S_MS         18'd88000
`define WD_175S_MS        18'd175000
`define DEAD_CYC          2'h2
`define REFRESH_CYC       4'h8

`endif

// ==== include/charger_pkg.sv ====
// types shared by the charger control block
// assumes charger_params.svh holds all numeric constants
package charger_pkg;

  // ---------------------------------------------------------
  // switch sequencer states
  // ---------------------------------------------------------
  typedef enum logic [2:0] {
    SW_OFF  = 3'b000,
    SW_DHS  = 3'b001,
    SW_HS   = 3'b010,
    SW_DLS  = 3'b011,
    SW_LS   = 3'b100
  } sw_state_t;

endpackage

// ==== hdl/charger_enable_pwm_control.sv ====
// charger enable, soft-start, watchdog, protection and switch sequencing
// assumes analog comparisons arrive as flags synchronous to core_clk
//
// Contract
// - start only when every enable condition holds
// - stop charging on any stop condition
// - soft-start from 128mA in 64mA steps
// - hold each step 240us, end at limit
// - discontinuous mode uses larger, longer steps
// - option bit selects monitored current source
// - monitor enabled above lockout and adapter detect
// - watchdog expires without voltage/current writes
// - expiry suspends charge, registers keep contents
// - voltage/current write clears suspension, restarts count
// - two-bit field selects off/44/88/175s
// - disabling watchdog after expiry resumes charging
// - high side until ramp crosses, then low
// - dead time between every switch transition
// - low bootstrap forces low-side refresh pulse
// - undercurrent turns low side off
// - low charge current or battery enters non-sync
// - leave non-sync above 250mA
// - blanked input overcurrent latches adapter switches off
// - option bit enables input overcurrent detection
// - battery overvoltage ignored at zero voltage setting
// - thermal shutdown with hysteresis, soft-start resume
`timescale 1ns/1ps
`include "charger_params.svh"

module charger_enable_pwm_control #(
  parameter logic [15:0] SS_CCM_CYC = 16'(`SS_CCM_CYC),
  parameter logic [15:0] SS_DCM_CYC = 16'(`SS_DCM_CYC),
  parameter logic [19:0] BLANK_CYC  = 20'(`BLANK_CYC),
  parameter logic [16:0] TICK_CYC   = 17'(`TICK_CYC)
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  // comparator flags
  input  wire logic        ilimAbove105,
  input  wire logic        ilimBelow75,
  input  wire logic        adapterGood,
  input  wire logic        adapterSwitchOn,
  input  wire logic        gateDriveOk,
  input  wire logic        batAbove104,
  input  wire logic        tempAbove155,
  input  wire logic        tempBelow135,
  input  wire logic        shortDetected,
  input  wire logic        sysAbove333,
  input  wire logic        uvloClear,
  input  wire logic        adapterDetectAbove06,
  input  wire logic        dcmMode,
  input  wire logic        rampAboveError,
  input  wire logic        rampReset,
  input  wire logic        bootstrapLow,
  input  wire logic        underCurrent,
  input  wire logic        avgBelow125,
  input  wire logic        avgAbove250,
  input  wire logic        batBelow25,
  // converter controls
  output logic             highSideOn,
  output logic             lowSideOn,
  output logic             adapterSwitchEnable,
  output logic             chargeActive,
  output logic      [15:0] chargeTarget,
  output logic             monitorEnable,
  output logic             monitorSelCharge
);
  import charger_pkg::*;

  // ---------------------------------------------------------
  // helpers
  // ---------------------------------------------------------
  function automatic logic dacOk(input logic [15:0] v, input logic [15:0] mx);
    dacOk = (v != 16'h0000) && (v <= mx);
  endfunction

  function automatic logic [17:0] wdLimit(input logic [1:0] sel);
    unique case (sel)
      `WD_44S:  wdLimit = `WD_44S_MS;
      `WD_88S:  wdLimit = `WD_88S_MS;
      `WD_175S: wdLimit = `WD_175S_MS;
      `WD_OFF:  wdLimit = 18'h3FFFF;
    endcase
  endfunction

  // ---------------------------------------------------------
  // register file and watchdog
  // ---------------------------------------------------------
  logic [15:0] optionReg, optionNext;
  logic [15:0] voltReg, voltNext;
  logic [15:0] currReg, currNext;
  logic [15:0] inCurReg, inCurNext;
  logic [15:0] rdReg, rdNext;
  logic [16:0] tickReg, tickNext;
  logic [17:0] msReg, msNext;
  logic        wdSuspReg, wdSuspNext;
  logic        kickWr, wdOffWr, wdExpire, tick;
  logic [15:0] statusWord;

  always_comb begin
    optionNext = optionReg;
    voltNext   = voltReg;
    currNext   = currReg;
    inCurNext  = inCurReg;
    kickWr     = 1'b0;
    wdOffWr    = 1'b0;
    if (regWr) begin
      unique case (regAddr)
        `ADDR_OPTION: begin
          optionNext = regWrData;
          wdOffWr = regWrData[`OPT_WD_HI:`OPT_WD_LO] == `WD_OFF;
        end
        `ADDR_TGT_VOLTAGE: begin
          voltNext = regWrData;
          kickWr = 1'b1;
        end
        `ADDR_TGT_CURRENT: begin
          currNext = regWrData;
          kickWr = 1'b1;
        end
        `ADDR_IN_CURRENT: inCurNext = regWrData;
        default: ;
      endcase
    end
    // unmapped and status addresses read as zero / status
    rdNext = 16'h0000;
    if (regRd) begin
      unique case (regAddr)
        `ADDR_OPTION:      rdNext = optionReg;
        `ADDR_TGT_VOLTAGE: rdNext = voltReg;
        `ADDR_TGT_CURRENT: rdNext = currReg;
        `ADDR_IN_CURRENT:  rdNext = inCurReg;
        `ADDR_STATUS:      rdNext = statusWord;
        default:           rdNext = 16'h0000;
      endcase
    end
    // millisecond tick keeps the watchdog counter narrow
    tick     = tickReg == TICK_CYC - 17'h00001;
    tickNext = tick ? 17'h00000 : tickReg + 17'h00001;
    wdExpire = (optionReg[`OPT_WD_HI:`OPT_WD_LO] != `WD_OFF) && tick &&
               (msReg + 18'h00001 >= wdLimit(optionReg[`OPT_WD_HI:`OPT_WD_LO]));
    msNext = msReg;
    if (kickWr || optionNext[`OPT_WD_HI:`OPT_WD_LO] != optionReg[`OPT_WD_HI:`OPT_WD_LO] ||
        optionReg[`OPT_WD_HI:`OPT_WD_LO] == `WD_OFF)
      msNext = 18'h00000;
    else if (wdExpire)
      msNext = 18'h00000;
    else if (tick)
      msNext = msReg + 18'h00001;
    // expiry wins over a coinciding clearing write; no register is touched
    if (wdExpire)
      wdSuspNext = 1'b1;
    else if (kickWr || wdOffWr)
      wdSuspNext = 1'b0;
    else
      wdSuspNext = wdSuspReg;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      optionReg <= `OPTION_RESET;
      voltReg   <= 16'h0000;
      currReg   <= 16'h0000;
      inCurReg  <= 16'h0000;
      rdReg     <= 16'h0000;
      tickReg   <= 17'h00000;
      msReg     <= 18'h00000;
      wdSuspReg <= 1'b0;
    end else begin
      optionReg <= optionNext;
      voltReg   <= voltNext;
      currReg   <= currNext;
      inCurReg  <= inCurNext;
      rdReg     <= rdNext;
      tickReg   <= tickNext;
      msReg     <= msNext;
      wdSuspReg <= wdSuspNext;
    end
  end

  assign regRdData = rdReg;

  // ---------------------------------------------------------
  // protection, enable and soft-start
  // ---------------------------------------------------------
  logic        ilimOkReg, ilimOkNext;
  logic        thermReg, thermNext;
  logic        ocLatchReg, ocLatchNext;
  logic [19:0] blankReg, blankNext;
  logic        chgReg, chgNext;
  logic [15:0] tgtReg, tgtNext;
  logic [15:0] ssCntReg, ssCntNext;
  logic        monEnReg, monEnNext;
  logic        monSelReg, monSelNext;
  logic        asEnReg, asEnNext;
  logic        battery_overvoltage, dacsOk, startOk, stopAny, ocArmed;
  logic [15:0] ssHold, ssStep, ssSum;

  always_comb begin
    // the analog side only ever reaches us as flags
    ilimOkNext = ilimAbove105 ? 1'b1 : (ilimBelow75 ? 1'b0 : ilimOkReg);
    thermNext  = tempAbove155 ? 1'b1 : (tempBelow135 ? 1'b0 : thermReg);
    battery_overvoltage = batAbove104 && (voltReg != 16'h0000);
    dacsOk = dacOk(voltReg, `VOLT_MAX) && dacOk(currReg, `CURR_MAX) &&
             dacOk(inCurReg, `INCUR_MAX);
    ocArmed = optionReg[`OPT_INPUT_OVERCURRENT_EN_BIT] && sysAbove333;
    blankNext = ocArmed ? ((blankReg == BLANK_CYC) ? blankReg : blankReg + 20'h00001) : 20'h00000;
    // latch is set on the blanked trip and only adapter-detect reset frees it
    if (blankReg == BLANK_CYC)
      ocLatchNext = 1'b1;
    else if (!adapterDetectAbove06)
      ocLatchNext = 1'b0;
    else
      ocLatchNext = ocLatchReg;
    asEnNext = !ocLatchNext;
    startOk = !optionReg[`OPT_INHIBIT_BIT] && ilimAbove105 && dacsOk && adapterGood &&
              adapterSwitchOn && gateDriveOk && !battery_overvoltage && !thermReg && !ocLatchReg && !shortDetected &&
              !wdSuspReg;
    stopAny = optionReg[`OPT_INHIBIT_BIT] || ilimBelow75 || !dacsOk || !adapterGood ||
              !adapterSwitchOn || battery_overvoltage || thermReg || ocLatchReg || shortDetected ||
              wdSuspReg;
    chgNext = chgReg ? !stopAny : startOk;
    ssHold = dcmMode ? SS_DCM_CYC : SS_CCM_CYC;
    ssStep = dcmMode ? `SS_STEP_DCM : `SS_STEP_CCM;
    ssSum  = tgtReg + ssStep;
    tgtNext   = tgtReg;
    ssCntNext = ssCntReg;
    if (chgNext && !chgReg) begin
      // every fresh enable, thermal resume included, restarts the ramp
      tgtNext   = (`SS_START < currReg) ? `SS_START : currReg;
      ssCntNext = 16'h0000;
    end else if (!chgReg) begin
      tgtNext   = 16'h0000;
      ssCntNext = 16'h0000;
    end else if (tgtReg != currReg) begin
      if (ssCntReg + 16'h0001 >= ssHold) begin
        ssCntNext = 16'h0000;
        if (tgtReg > currReg || ssSum >= currReg)
          tgtNext = currReg;
        else
          tgtNext = ssSum;
      end else begin
        ssCntNext = ssCntReg + 16'h0001;
      end
    end
    monEnNext  = uvloClear && adapterDetectAbove06;
    monSelNext = optionReg[`OPT_MON_SEL_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ilimOkReg  <= 1'b0;
      thermReg   <= 1'b0;
      ocLatchReg <= 1'b0;
      blankReg   <= 20'h00000;
      chgReg     <= 1'b0;
      tgtReg     <= 16'h0000;
      ssCntReg   <= 16'h0000;
      monEnReg   <= 1'b0;
      monSelReg  <= 1'b0;
      asEnReg    <= 1'b0;
    end else begin
      ilimOkReg  <= ilimOkNext;
      thermReg   <= thermNext;
      ocLatchReg <= ocLatchNext;
      blankReg   <= blankNext;
      chgReg     <= chgNext;
      tgtReg     <= tgtNext;
      ssCntReg   <= ssCntNext;
      monEnReg   <= monEnNext;
      monSelReg  <= monSelNext;
      asEnReg    <= asEnNext;
    end
  end

  assign chargeActive        = chgReg;
  assign chargeTarget        = tgtReg;
  assign monitorEnable       = monEnReg;
  assign monitorSelCharge    = monSelReg;
  assign adapterSwitchEnable = asEnReg;

  // ---------------------------------------------------------
  // switch sequencing
  // ---------------------------------------------------------
  sw_state_t   swReg, swNext;
  logic [1:0]  deadReg, deadNext;
  logic [3:0]  refReg, refNext;
  logic        nsReg, nsNext;
  logic        hsReg, hsNext;
  logic        lsReg, lsNext;
  logic        deadDone;

  always_comb begin
    // entry wins over exit when both thresholds flag together
    if (avgBelow125 || batBelow25)
      nsNext = 1'b1;
    else if (avgAbove250)
      nsNext = 1'b0;
    else
      nsNext = nsReg;
    deadDone = deadReg == `DEAD_CYC - 2'h1;
    swNext   = swReg;
    deadNext = 2'h0;
    refNext  = refReg;
    unique case (swReg)
      SW_OFF: begin
        if (chgReg && rampReset)
          swNext = SW_DHS;
      end
      SW_DHS: begin
        deadNext = deadReg + 2'h1;
        if (deadDone)
          swNext = rampAboveError ? SW_OFF : SW_HS;
      end
      SW_HS: begin
        if (rampAboveError || bootstrapLow) begin
          swNext  = SW_DLS;
          refNext = bootstrapLow ? `REFRESH_CYC : 4'h0;
        end
      end
      SW_DLS: begin
        deadNext = deadReg + 2'h1;
        if (deadDone)
          swNext = (refReg != 4'h0 || (!nsReg && !underCurrent)) ? SW_LS : SW_OFF;
      end
      SW_LS: begin
        if (refReg != 4'h0)
          refNext = refReg - 4'h1;
        if (rampReset)
          swNext = SW_DHS;
        else if (refReg == 4'h1)
          swNext = SW_OFF;
        else if (refReg == 4'h0 && (underCurrent || nsReg))
          swNext = SW_OFF;
      end
      default: swNext = SW_OFF;
    endcase
    // turning a switch off is always safe, so a stop skips the dead time
    if (!chgReg)
      swNext = SW_OFF;
    hsNext = swNext == SW_HS;
    lsNext = swNext == SW_LS;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      swReg   <= SW_OFF;
      deadReg <= 2'h0;
      refReg  <= 4'h0;
      nsReg   <= 1'b1;
      hsReg   <= 1'b0;
      lsReg   <= 1'b0;
    end else begin
      swReg   <= swNext;
      deadReg <= deadNext;
      refReg  <= refNext;
      nsReg   <= nsNext;
      hsReg   <= hsNext;
      lsReg   <= lsNext;
    end
  end

  assign highSideOn = hsReg;
  assign lowSideOn  = lsReg;

  // ---------------------------------------------------------
  // status word
  // ---------------------------------------------------------
  assign statusWord = {8'h00, ilimOkReg, monEnReg, (tgtReg != currReg), nsReg,
                       thermReg, ocLatchReg, wdSuspReg, chgReg};

endmodule

// ==== tb/charger_checker_properties.sv ====
// concurrent checks on the charger enable / pwm control ports
// assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
`include "charger_params.svh"
module charger_checker_properties #(
  parameter logic [19:0] BLANK_CYC = 20'h14
) (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // register port
  input wire logic [3:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  // comparator flags
  input wire logic        sysAbove333,
  input wire logic        adapterDetectAbove06,
  input wire logic        uvloClear,
  input wire logic        batBelow25,
  input wire logic        bootstrapLow,
  // converter controls
  input wire logic        highSideOn,
  input wire logic        lowSideOn,
  input wire logic        adapterSwitchEnable,
  input wire logic        chargeActive,
  input wire logic [15:0] chargeTarget,
  input wire logic        monitorEnable,
  input wire logic        monitorSelCharge
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------
  logic [19:0] ocRun_reg;
  logic [19:0] ocRun_next;
  logic        selBit;
  assign selBit = regWrData[`OPT_MON_SEL_BIT];
  // saturate so a stuck overcurrent flag cannot wrap the run length
  always_comb begin
    ocRun_next = 20'h0;
    if (sysAbove333) begin
      ocRun_next = (ocRun_reg == 20'hFFFFF) ? ocRun_reg : ocRun_reg + 20'h1;
    end
  end
  always_ff @(posedge core_clk) begin
    ocRun_reg <= rst_n ? ocRun_next : 20'h0;
  end
  // ---------------------------------------------------------
  // properties
  // ---------------------------------------------------------
  sequence s_quiet;
    batBelow25 && !bootstrapLow;
  endsequence
  sequence s_dead_ls;
    !lowSideOn ##1 !lowSideOn;
  endsequence
  sequence s_dead_hs;
    !highSideOn ##1 !highSideOn;
  endsequence
  property p_no_overlap;
    !(highSideOn && lowSideOn);
  endproperty
  property p_dead_hl;
    $fell(highSideOn) |-> s_dead_ls;
  endproperty
  property p_dead_lh;
    $fell(lowSideOn) |-> s_dead_hs;
  endproperty
  property p_stop;
    $fell(chargeActive) |-> ##1 (!highSideOn && !lowSideOn);
  endproperty
  property p_ss_start;
    $rose(chargeActive) |-> chargeTarget != 16'h0000 && chargeTarget <= `SS_START;
  endproperty
  property p_ss_hold;
    $changed(chargeTarget) && chargeActive |->
      ##1 (!chargeActive || $rose(chargeActive) || $stable(chargeTarget))[*7];
  endproperty
  property p_mon_en;
    monitorEnable |-> $past(uvloClear) && $past(adapterDetectAbove06);
  endproperty
  property p_mon_sel;
    regWr && regAddr == `ADDR_OPTION |-> ##2 monitorSelCharge == $past(selBit, 2);
  endproperty
  property p_oc_blank;
    $fell(adapterSwitchEnable) && $past(adapterDetectAbove06) |-> ocRun_reg > BLANK_CYC;
  endproperty
  property p_nosync;
    s_quiet[*4] ##1 (batBelow25 && !bootstrapLow && !lowSideOn) ##1 s_quiet[*4] |-> !lowSideOn;
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both switches on");
  a_dead_hl: assert property (p_dead_hl) else $error("short dead time after high side");
  a_dead_lh: assert property (p_dead_lh) else $error("short dead time after low side");
  a_stop: assert property (p_stop) else $error("switching after charge stop");
  a_ss_start: assert property (p_ss_start) else $error("bad soft-start origin");
  a_ss_hold: assert property (p_ss_hold) else $error("soft-start step too short");
  a_mon_en: assert property (p_mon_en) else $error("monitor on without supply");
  a_mon_sel: assert property (p_mon_sel) else $error("monitor source mismatch");
  a_oc_blank: assert property (p_oc_blank) else $error("overcurrent latched early");
  a_nosync: assert property (p_nosync) else $error("low side on in non-sync");
endmodule

bind charger_enable_pwm_control charger_checker_properties #(.BLANK_CYC(BLANK_CYC)) charger_checker_properties_i (
  .core_clk, .rst_n, .regAddr, .regWrData, .regWr, .sysAbove333, .adapterDetectAbove06,
  .uvloClear, .batBelow25, .bootstrapLow, .highSideOn, .lowSideOn, .adapterSwitchEnable,
  .chargeActive, .chargeTarget, .monitorEnable, .monitorSelCharge
);

// ==== tb/converter_model.sv ====
// stand-in for the power stage: ramp, cycle start, bootstrap, undercurrent
// assumes switch gates from the charger block on the same clock
`timescale 1ns/1ps
module converter_model (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // switch gates and mode
  input  wire logic highSideOn,
  input  wire logic lowSideOn,
  input  wire logic dcmOn,
  // comparator flags
  output logic      rampReset,
  output logic      rampAboveError,
  output logic      bootstrapLow,
  output logic      underCurrent
);
  logic [4:0] phase_reg;
  logic [6:0] noLs_reg;
  logic [2:0] lsOn_reg;
  always_ff @(posedge core_clk) begin
    phase_reg <= (!rst_n || phase_reg == 5'h17) ? 5'h00 : phase_reg + 5'h01;
    noLs_reg  <= (!rst_n || lowSideOn) ? 7'h00 : noLs_reg + {6'h00, noLs_reg != 7'h7F};
    lsOn_reg  <= lowSideOn ? lsOn_reg + {2'h0, lsOn_reg != 3'h7} : 3'h0;
  end
  assign rampReset      = phase_reg == 5'h00;
  assign rampAboveError = phase_reg >= 5'h0E;
  // bootstrap sags only after a long stretch without low-side conduction
  assign bootstrapLow   = noLs_reg >= 7'h3C;
  assign underCurrent   = dcmOn && lsOn_reg >= 3'h3;
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the charger enable / pwm control block
// assumes the converter stand-in model and the bound checker
`timescale 1ns/1ps
`include "charger_params.svh"
module testbench;
  logic        core_clk, rst_n, regWr, regRd;
  logic [3:0]  regAddr;
  logic [15:0] regWrData, regRdData, chargeTarget;
  logic [4:0]  okv;
  logic        tAbove, tBelow, sys, undervoltage_lockout, det, dcm, avgHi, batLow, avgLo;
  logic        highSideOn, lowSideOn, adapterSwitchEnable, chargeActive, monitorEnable, monitorSelCharge;
  logic        rampReset, rampAboveError, bootstrapLow, underCurrent;
  int          miscompares, testsRun, hs, ls;

  // short counts keep the run small: steps 8/16, blanking 20, 1-cycle tick
  charger_enable_pwm_control #(.SS_CCM_CYC(16'h8), .SS_DCM_CYC(16'h10), .BLANK_CYC(20'h14),
    .TICK_CYC(17'h1)) charger_enable_pwm_control_i (
    .core_clk(core_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .ilimAbove105(okv[0]), .ilimBelow75(!okv[0]),
    .adapterGood(okv[1]), .adapterSwitchOn(okv[2]), .gateDriveOk(1'b1), .batAbove104(!okv[3]),
    .tempAbove155(tAbove), .tempBelow135(tBelow), .shortDetected(!okv[4]), .sysAbove333(sys),
    .uvloClear(undervoltage_lockout), .adapterDetectAbove06(det), .dcmMode(dcm), .rampAboveError(rampAboveError),
    .rampReset(rampReset), .bootstrapLow(bootstrapLow), .underCurrent(underCurrent),
    .avgBelow125(avgLo), .avgAbove250(avgHi), .batBelow25(batLow), .highSideOn(highSideOn),
    .lowSideOn(lowSideOn), .adapterSwitchEnable(adapterSwitchEnable), .chargeActive(chargeActive),
    .chargeTarget(chargeTarget), .monitorEnable(monitorEnable), .monitorSelCharge(monitorSelCharge));

  converter_model converter_model_i (
    .core_clk(core_clk), .rst_n(rst_n), .highSideOn(highSideOn), .lowSideOn(lowSideOn), .dcmOn(dcm),
    .rampReset(rampReset), .rampAboveError(rampAboveError), .bootstrapLow(bootstrapLow),
    .underCurrent(underCurrent));

  // ---------------------------------------------------------
  // tasks
  // ---------------------------------------------------------
  task automatic conclude();
    if (miscompares == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    @(negedge core_clk);
    chk(regRdData, e);
  endtask
  // bounded wait for the charge enable to reach a level, then compare
  task automatic waitAct(input logic v);
    int n;
    n = 0;
    @(negedge core_clk);
    while (chargeActive !== v && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk(16'(chargeActive), 16'(v));
  endtask

  // ---------------------------------------------------------
  // clock, watchdog and tests
  // ---------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (85000) @(posedge core_clk);
    miscompares++;
    conclude();
  end
  initial begin
    miscompares = 0;
    testsRun = 0;
    rst_n = 1'b0;
    {regWr, regRd, regAddr, regWrData} = '0;
    okv = 5'h1F;
    {tAbove, sys, dcm, avgHi, batLow, avgLo} = '0;
    {tBelow, undervoltage_lockout, det} = 3'h7;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`ADDR_OPTION, `OPTION_RESET);
    wr(4'h5, 16'hFFFF);
    rd(4'h5, 16'h0000);
    cyc(4);
    chk(16'(chargeActive), 16'h0000);
    wr(`ADDR_TGT_VOLTAGE, 16'h3000);
    wr(`ADDR_TGT_CURRENT, 16'h0200);
    wr(`ADDR_IN_CURRENT, 16'h0800);
    waitAct(1'b1);
    chk(chargeTarget, `SS_START);
    cyc(7);
    chk(chargeTarget, `SS_START);
    cyc(1);
    chk(chargeTarget, 16'h00C0);
    cyc(40);
    chk(chargeTarget, 16'h0200);
    cyc(16);
    chk(chargeTarget, 16'h0200);
    // leave non-sync once, then count gates in sync, low-battery and low-current mode
    @(posedge core_clk);
    avgHi <= 1'b1;
    cyc(2);
    @(posedge core_clk);
    avgHi <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      @(posedge core_clk);
      {batLow, avgLo} <= {m == 1, m == 2};
      hs = 0;
      ls = 0;
      repeat (200) begin
        @(negedge core_clk);
        if (highSideOn === 1'b1) hs++;
        if (lowSideOn === 1'b1) ls++;
      end
      chk(16'(hs != 0), 16'h0001);
      chk(16'(ls != 0), 16'h0001);
    end
    @(posedge core_clk);
    {batLow, avgLo} <= 2'h0;
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk);
      okv[i] <= 1'b0;
      waitAct(1'b0);
      @(posedge core_clk);
      okv[i] <= 1'b1;
      waitAct(1'b1);
      chk(chargeTarget, `SS_START);
    end
    @(posedge core_clk);
    tAbove <= 1'b1;
    tBelow <= 1'b0;
    waitAct(1'b0);
    @(posedge core_clk);
    tAbove <= 1'b0;
    cyc(10);
    chk(16'(chargeActive), 16'h0000);
    @(posedge core_clk);
    tBelow <= 1'b1;
    waitAct(1'b1);
    chk(chargeTarget, `SS_START);
    wr(`ADDR_OPTION, 16'h6003);
    waitAct(1'b0);
    wr(`ADDR_OPTION, `OPTION_RESET);
    waitAct(1'b1);
    wr(`ADDR_TGT_CURRENT, 16'h0000);
    waitAct(1'b0);
    wr(`ADDR_TGT_CURRENT, 16'h2000);
    cyc(10);
    chk(16'(chargeActive), 16'h0000);
    wr(`ADDR_TGT_CURRENT, 16'h0200);
    waitAct(1'b1);
    @(posedge core_clk);
    dcm <= 1'b1;
    wr(`ADDR_OPTION, 16'h6003);
    waitAct(1'b0);
    wr(`ADDR_OPTION, `OPTION_RESET);
    waitAct(1'b1);
    cyc(15);
    chk(chargeTarget, `SS_START);
    cyc(1);
    chk(chargeTarget, 16'h0100);
    @(posedge core_clk);
    dcm <= 1'b0;
    wr(`ADDR_OPTION, 16'h6022);
    cyc(3);
    chk(16'(monitorSelCharge), 16'h0001);
    chk(16'(monitorEnable), 16'h0001);
    @(posedge core_clk);
    undervoltage_lockout <= 1'b0;
    cyc(3);
    chk(16'(monitorEnable), 16'h0000);
    @(posedge core_clk);
    undervoltage_lockout <= 1'b1;
    wr(`ADDR_OPTION, `OPTION_RESET);
    cyc(3);
    chk(16'(monitorSelCharge), 16'h0000);
    // a burst shorter than the blanking span must not latch
    @(posedge core_clk);
    sys <= 1'b1;
    cyc(10);
    @(posedge core_clk);
    sys <= 1'b0;
    cyc(5);
    chk(16'(adapterSwitchEnable), 16'h0001);
    @(posedge core_clk);
    sys <= 1'b1;
    cyc(30);
    @(posedge core_clk);
    sys <= 1'b0;
    cyc(20);
    chk(16'(adapterSwitchEnable), 16'h0000);
    chk(16'(chargeActive), 16'h0000);
    @(posedge core_clk);
    det <= 1'b0;
    cyc(3);
    chk(16'(monitorEnable), 16'h0000);
    @(posedge core_clk);
    det <= 1'b1;
    cyc(3);
    chk(16'(adapterSwitchEnable), 16'h0001);
    waitAct(1'b1);
    wr(`ADDR_OPTION, 16'h6000);
    @(posedge core_clk);
    sys <= 1'b1;
    cyc(30);
    chk(16'(adapterSwitchEnable), 16'h0001);
    @(posedge core_clk);
    sys <= 1'b0;
    wr(`ADDR_OPTION, 16'h2002);
    cyc(30000);
    wr(`ADDR_TGT_VOLTAGE, 16'h3000);
    cyc(30000);
    chk(16'(chargeActive), 16'h0001);
    cyc(13900);
    chk(16'(chargeActive), 16'h0001);
    cyc(200);
    chk(16'(chargeActive), 16'h0000);
    rd(`ADDR_TGT_CURRENT, 16'h0200);
    rd(`ADDR_OPTION, 16'h2002);
    rd(`ADDR_STATUS, 16'h00F2);
    wr(`ADDR_OPTION, 16'h0002);
    waitAct(1'b1);
    conclude();
  end
endmodule
